// file: rtl/dhrs_pkg.sv
// Constants for the display hardware reset sequencer.
// Assumes a single 40 MHz clock; times are converted to cycle counts here.
package dhrs_pkg;
   localparam int CLK_HZ = 40_000_000;
   // Spike rejection: shorter than 5 us never resets, longer than 9 us always does
   localparam int REJECT_US = 5;
   localparam int ACCEPT_US = 9;
   // Reset cancel interval and blanking limits
   localparam int CANCEL_SLEEP_MS = 5;
   localparam int CANCEL_AWAKE_MS = 120;
   localparam int BLANK_MAX_MS = 120;
   // Accept threshold placed midway, and rounded down so it stays below 9 us
   localparam int ACCEPT_CYC = ((REJECT_US + ACCEPT_US) * (CLK_HZ / 1_000_000)) / 2;
   // Glitch filter: high blips shorter than half the reject time cannot end a held reset
   localparam int GLITCH_CYC = (REJECT_US * (CLK_HZ / 1_000_000)) / 2;
   // Longest times round down
   localparam int CANCEL_SLEEP_CYC = CANCEL_SLEEP_MS * (CLK_HZ / 1_000);
   localparam int CANCEL_AWAKE_CYC = CANCEL_AWAKE_MS * (CLK_HZ / 1_000);
   localparam int BLANK_CYC = BLANK_MAX_MS * (CLK_HZ / 1_000);
   localparam int CNT_W = 24;
   localparam logic RESET_SLEEP = 1'b1;
endpackage

// file: rtl/dhrs_pulse_filter.sv
// Low-pulse qualifier for the reset pin.
// Assumes line_n is already synchronised to clk.
`timescale 1ns/1ps
module dhrs_pulse_filter #(
   parameter int ACCEPT = 200,
   parameter int GLITCH = 100,
   parameter int W = 24
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic line_n,
   output logic reset_active
);
   logic [W-1:0] low_reg, low_next;
   logic [W-1:0] high_reg, high_next;
   logic act_reg, act_next;

   always_comb begin
      low_next = low_reg;
      high_next = high_reg;
      act_next = act_reg;
      if (!line_n) begin
         high_next = '0;
         if (low_reg != W'(ACCEPT))
            low_next = low_reg + 1'b1;
         if (low_reg == W'(ACCEPT - 1))
            act_next = 1'b1;
      end else begin
         low_next = '0;
         if (high_reg != W'(GLITCH))
            high_next = high_reg + 1'b1;
         // Short high spikes inside a valid pulse are ignored
         if (high_reg == W'(GLITCH - 1))
            act_next = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         low_reg <= '0;
         high_reg <= '0;
         act_reg <= 1'b0;
      end else begin
         low_reg <= low_next;
         high_reg <= high_next;
         act_reg <= act_next;
      end
   end

   assign reset_active = act_reg;
endmodule // dhrs_pulse_filter

// file: rtl/dhrs_sequencer.sv
// Reset sequencer for a display controller: filters the reset pin, blanks the
// panel, reloads stored settings on release and signals when commands may run.
// Assumes the nonvolatile store answers a load request with a done pulse.
`timescale 1ns/1ps
module dhrs_sequencer #(
   parameter int CANCEL_SLEEP = dhrs_pkg::CANCEL_SLEEP_CYC,
   parameter int CANCEL_AWAKE = dhrs_pkg::CANCEL_AWAKE_CYC,
   parameter int BLANK_TIME = dhrs_pkg::BLANK_CYC
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic hw_reset_line_n,
   input wire logic sleeping,
   input wire logic nvm_done,
   output logic nvm_load,
   output logic display_blank,
   output logic core_reset,
   output logic ready
);
   typedef enum logic [2:0] {
      DHRS_RUN,
      DHRS_BLANKING,
      DHRS_HELD,
      DHRS_LOAD,
      DHRS_CANCEL
   } dhrs_state_e;

   localparam int CW = dhrs_pkg::CNT_W;

   logic sync1_reg, sync2_reg;
   logic reset_active;
   dhrs_state_e state_reg, state_next;
   logic [CW-1:0] cnt_reg, cnt_next;
   logic [CW-1:0] limit_reg, limit_next;
   logic sleep_reg, sleep_next;
   logic load_reg, load_next;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sync1_reg <= 1'b1;
         sync2_reg <= 1'b1;
      end else begin
         sync1_reg <= hw_reset_line_n;
         sync2_reg <= sync1_reg;
      end
   end

   dhrs_pulse_filter #(
      .ACCEPT(dhrs_pkg::ACCEPT_CYC),
      .GLITCH(dhrs_pkg::GLITCH_CYC),
      .W(CW)
   ) u_filter (
      .clk(clk),
      .nrst(nrst),
      .line_n(sync2_reg),
      .reset_active(reset_active)
   );

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      limit_next = limit_reg;
      sleep_next = sleep_reg;
      load_next = 1'b0;
      unique case (state_reg)
         DHRS_RUN: begin
            if (reset_active) begin
               sleep_next = sleeping;
               cnt_next = '0;
               // Awake start runs the blanking sequence; asleep stays blank
               state_next = sleeping ? DHRS_HELD : DHRS_BLANKING;
            end
         end
         DHRS_BLANKING: begin
            cnt_next = cnt_reg + 1'b1;
            if (cnt_reg >= CW'(BLANK_TIME - 1))
               state_next = DHRS_HELD;
            if (!reset_active) begin
               state_next = DHRS_LOAD;
               load_next = 1'b1;
               cnt_next = '0;
            end
         end
         DHRS_HELD: begin
            if (!reset_active) begin
               state_next = DHRS_LOAD;
               load_next = 1'b1;
               cnt_next = '0;
            end
         end
         DHRS_LOAD: begin
            cnt_next = cnt_reg + 1'b1;
            limit_next = sleep_reg ? CW'(CANCEL_SLEEP) : CW'(CANCEL_AWAKE);
            if (reset_active) begin
               state_next = DHRS_HELD;
            end else if (nvm_done) begin
               state_next = DHRS_CANCEL;
            end
         end
         DHRS_CANCEL: begin
            cnt_next = cnt_reg + 1'b1;
            if (reset_active)
               state_next = DHRS_HELD;
            else if (cnt_reg >= limit_reg - 1'b1)
               state_next = DHRS_RUN;
         end
         default: state_next = DHRS_RUN;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= DHRS_HELD;
         cnt_reg <= '0;
         limit_reg <= CW'(CANCEL_SLEEP);
         sleep_reg <= dhrs_pkg::RESET_SLEEP;
         load_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         limit_reg <= limit_next;
         sleep_reg <= sleep_next;
         load_reg <= load_next;
      end
   end

   // Load is requested on release; the cancel window counts from the request, so it stretches only if the store outlasts it
   assign nvm_load = load_reg;
   assign display_blank = (state_reg != DHRS_RUN);
   assign core_reset = (state_reg == DHRS_BLANKING) || (state_reg == DHRS_HELD);
   assign ready = (state_reg == DHRS_RUN);
endmodule // dhrs_sequencer

// file: verif/dhrs_checker_sva.sv
// Port checker for the reset sequencer.
// Assumes the top module's clk and nrst.
`timescale 1ns/1ps
module dhrs_checker (
   input wire logic clk,
   input wire logic nrst,
   input wire logic hw_reset_line_n,
   input wire logic nvm_load,
   input wire logic display_blank,
   input wire logic core_reset,
   input wire logic ready
);
   logic pin_q;
   logic [9:0] run;
   // Set once ready has been seen, so the boot release is not read as a pulse end
   logic armed;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // Run length of the raw pin level, saturating
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pin_q <= 1'b1;
         run <= 10'h000;
         armed <= 1'b0;
      end else begin
         armed <= armed | ready;
         pin_q <= hw_reset_line_n;
         run <= (hw_reset_line_n != pin_q) ? 10'h000 : run + {9'h000, ~&run};
      end
   end
   a_short_reject: assert property ($rose(core_reset) |-> !$past(hw_reset_line_n, 200))
      else $error("reset began on a short low pulse");
   a_long_accept: assert property (!hw_reset_line_n && run == 10'h16A |-> ##[0:4] core_reset)
      else $error("long low pulse not taken as reset");
   a_spike_hold: assert property (armed && $fell(core_reset) |-> $past(hw_reset_line_n, 90))
      else $error("reset left on a short high spike");
   a_load_release: assert property (hw_reset_line_n && run == 10'h064 && core_reset
      |-> ##[1:8] nvm_load)
      else $error("no reload after release");
   a_run_unblank: assert property (display_blank != ready)
      else $error("blank and ready disagree");
   a_reset_blank: assert property (core_reset |-> display_blank)
      else $error("display shown during reset");
   c_ready: cover property ($rose(ready));
   c_load: cover property (nvm_load);
   c_accept: cover property ($rose(core_reset));
endmodule // dhrs_checker
bind dhrs_sequencer dhrs_checker dhrs_checker_inst (.clk, .nrst, .hw_reset_line_n,
   .nvm_load, .display_blank, .core_reset, .ready);

// file: verif/dhrs_host_model.sv
// Host pin driver and stand-in settings store.
// Assumes width is held while start is high.
`timescale 1ns/1ps
module dhrs_host_model (
   input wire logic clk,
   input wire logic start,
   input wire logic [15:0] width,
   input wire logic nvm_load,
   output logic hw_reset_line_n,
   output logic nvm_done
);
   logic [15:0] left = 16'h0000;
   logic [1:0] lag = 2'h0;
   // Low time counted on the shared clk, so it never depends on the device outputs
   always_ff @(posedge clk) begin
      if (start) left <= width;
      else if (left != 16'h0000) left <= left - 16'h0001;
      lag <= {lag[0], nvm_load};
   end
   assign hw_reset_line_n = (left == 16'h0000);
   assign nvm_done = lag[1];
endmodule // dhrs_host_model

// file: verif/tb_dhrs_sequencer.sv
// Self-checking bench for the reset sequencer.
// Assumes the host model drives the pin and answers loads.
`timescale 1ns/1ps
module tb_dhrs_sequencer;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic sleeping = 1'b0;
   logic start = 1'b0;
   logic [15:0] width = 16'h0000;
   logic hw_reset_line_n, nvm_done, nvm_load, display_blank, core_reset, ready;
   int mismatches = 0;
   int checks_done = 0;
   int n_load, n_rst, n_cancel;
   initial begin
      forever #12.5 clk = ~clk;
   end
   dhrs_sequencer #(.CANCEL_SLEEP(50), .CANCEL_AWAKE(80), .BLANK_TIME(60)) dhrs_sequencer_inst (
      .clk, .nrst, .hw_reset_line_n, .sleeping, .nvm_done, .nvm_load, .display_blank,
      .core_reset, .ready);
   dhrs_host_model dhrs_host_model_inst (.clk, .start, .width, .nvm_load, .hw_reset_line_n,
      .nvm_done);
   task automatic check(input string what, input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask
   // Low pulse of w cycles, watched for cyc cycles from its start
   task automatic hold(input logic [15:0] w, input int cyc);
      @(posedge clk);
      start <= 1'b1;
      width <= w;
      @(posedge clk);
      start <= 1'b0;
      repeat (cyc) begin
         @(negedge clk);
         n_load += int'(nvm_load === 1'b1);
         n_rst += int'(core_reset === 1'b1);
         n_cancel += int'(display_blank === 1'b1 && core_reset === 1'b0);
      end
   endtask
   task automatic t_short;
      n_load = 0;
      n_rst = 0;
      hold(16'h00BE, 600);
      check("short_no_reset", n_rst == 0, 1'b1);
      check("short_no_load", n_load == 0, 1'b1);
      $display("test short_pulse done");
   endtask
   task automatic t_awake;
      @(posedge clk);
      sleeping <= 1'b0;
      n_load = 0;
      n_rst = 0;
      n_cancel = 0;
      hold(16'h0190, 900);
      check("awake_blanked", n_rst > 200, 1'b1);
      check("awake_one_load", n_load == 1, 1'b1);
      check("awake_cancel", n_cancel > 52 && n_cancel <= 82, 1'b1);
      check("awake_ready", ready, 1'b1);
      $display("test awake_reset done");
   endtask
   task automatic t_sleep_spike;
      @(posedge clk);
      sleeping <= 1'b1;
      n_load = 0;
      n_cancel = 0;
      hold(16'h0190, 450);
      hold(16'h0190, 700);
      check("spike_one_load", n_load == 1, 1'b1);
      check("sleep_cancel", n_cancel <= 52, 1'b1);
      check("sleep_ready", ready, 1'b1);
      $display("test sleep_spike done");
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      // No traffic until the cancel interval is over
      repeat (200) @(negedge clk);
      check("boot_ready", ready, 1'b1);
      t_short();
      t_awake();
      t_sleep_spike();
      conclude();
   end
   initial begin
      #200_000;
      mismatches++;
      conclude();
   end
endmodule // tb_dhrs_sequencer
